// ===== dv/stc_remote_node.sv
// Remote serial node on the differential pairs
`timescale 1ns/1ns
module stc_remote_node
(
    input  wire logic core_clk_i,
    output logic      line_o,
    output logic      de_o
);
    // ==========================================================
    // Idle: driver off, pull-apart resistors bias line to mark
    // ==========================================================
    initial
    begin
        line_o = 1'b1;
        de_o   = 1'b0;
    end

    // ==========================================================
    // One 8N1 character, LSB first, d clocks per bit
    // ==========================================================
    task automatic send_byte(input logic [7:0] b, input int unsigned d);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        @(posedge core_clk_i);
        #2;
        de_o = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            line_o = frame[i];
            repeat (d) @(posedge core_clk_i);
            #2;
        end
        de_o   = 1'b0;
        line_o = 1'b1;
    endtask
endmodule // stc_remote_node

// ===== dv/stc_serial_ctrl_tb_top.sv
// Self-checking testbench of the serial transceiver control block
`timescale 1ns/1ns
module stc_serial_ctrl_tb_top;
    import stc_pkg::*;

    // ==========================================================
    // Signals
    // ==========================================================
    logic             core_clk;
    logic             srst;
    logic [2:0][15:0] div;
    logic [2:0][7:0]  txd;
    logic [2:0]       txv;
    logic [2:0]       txr;
    logic [2:0][7:0]  rxd;
    logic [2:0]       rxv;
    logic [2:0]       ferr;
    logic [1:0]       s232;
    logic             mode;
    logic             rts;
    logic             drts;
    logic             de;
    logic             dtx;
    logic             pdreq;
    logic             pd;
    wire              node_line;
    wire              node_de;
    wire              bus_lvl;
    int               error_cnt   = 0;
    int               check_count = 0;

    // Shared pair: our driver, else remote, else idle bias
    assign bus_lvl = de ? dtx : (node_de ? node_line : 1'b1);

    stc_serial_ctrl stc_serial_ctrl_i (
        .core_clk_i               (core_clk),
        .srst_i                   (srst),
        .ch_div_i                 (div),
        .ch_tx_data_i             (txd),
        .ch_tx_valid_i            (txv),
        .ch_tx_ready_o            (txr),
        .ch_rx_data_o             (rxd),
        .ch_rx_valid_o            (rxv),
        .ch_rx_ferr_o             (ferr),
        .rs232_txd_o              (s232),
        .rs232_rxd_i              (s232),
        .rs485_mode_i             (mode),
        .rts_req_i                (rts),
        .diff_rts_o               (drts),
        .diff_de_o                (de),
        .diff_txd_o               (dtx),
        .diff_rx422_i             (node_line),
        .diff_bus_i               (bus_lvl),
        .pwrdn_req_i              (pdreq),
        .rs232_buffer_powerdown_o (pd)
    );

    stc_remote_node stc_remote_node_i (
        .core_clk_i (core_clk),
        .line_o     (node_line),
        .de_o       (node_de)
    );

    always #50 core_clk = ~core_clk;

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick;
        @(posedge core_clk);
        #2;
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic send(input int ch, input logic [7:0] b);
        txd[ch] = b;
        txv[ch] = 1'b1;
        tick();
        txv[ch] = 1'b0;
        check(16'(txr[ch]), 16'h0000);
        check(16'(ch < 2 ? s232[ch] : dtx), 16'h0000);
    endtask

    task automatic wait_rx(input int ch, input logic [7:0] exp);
        int n;
        n = 0;
        while (rxv[ch] !== 1'b1)
        begin
            tick();
            n++;
            if (n > 3000)
            begin
                error_cnt++;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, 8'h00, exp);
                report_and_stop();
            end
        end
        check(16'(rxd[ch]), 16'(exp));
        check(16'(ferr[ch]), 16'h0000);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        check(16'(drts), 16'h0001);
        check(16'(de), 16'h0000);
        check(16'(pd), 16'h0000);
        check(16'(txr), 16'h0007);
        check(16'({s232, dtx}), 16'h0007);
    endtask

    task automatic t_pwrdn;
        pdreq = 1'b1;
        tick();
        check(16'(pd), 16'h0001);
        pdreq = 1'b0;
        tick();
        check(16'(pd), 16'h0000);
    endtask

    task automatic t_rts;
        for (int m = 0; m < 2; m++)
        begin
            mode = m[0];
            rts  = 1'b0;
            tick();
            check(16'(de), 16'h0001);
            check(16'(drts), 16'h0000);
            rts = 1'b1;
            tick();
            check(16'(de), 16'h0000);
            check(16'(drts), 16'h0001);
        end
    endtask

    task automatic t_rs232;
        send(0, 8'ha5);
        wait_rx(0, 8'ha5);
        // Divisor below floor must be raised: mid bit 1 of 0x3c is low
        send(1, 8'h3c);
        repeat (2 * MIN_DIV + MIN_DIV / 2) tick();
        check(16'(s232[1]), 16'h0000);
        wait_rx(1, 8'h3c);
    endtask

    task automatic t_rs485;
        mode = 1'b1;
        rts  = 1'b0;
        tick();
        send(2, 8'h5a);
        wait_rx(2, 8'h5a);
        // Echo arrives mid stop bit; let the stop bit leave the line
        repeat (MIN_DIV) tick();
        check(16'(txr[2]), 16'h0001);
        rts = 1'b1;
        tick();
        check(16'(de), 16'h0000);
        fork
            stc_remote_node_i.send_byte(8'hc3, 87);
            wait_rx(2, 8'hc3);
        join
    endtask

    task automatic t_rs422;
        mode = 1'b0;
        rts  = 1'b0;
        tick();
        fork
            stc_remote_node_i.send_byte(8'h96, 87);
            begin
                send(2, 8'h69);
                wait_rx(2, 8'h96);
            end
        join
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        core_clk = 1'b0;
        srst     = 1'b1;
        div      = {16'h0057, 16'h000a, 16'h0057};
        txd      = '0;
        txv      = 3'h0;
        mode     = 1'b0;
        rts      = 1'b1;
        pdreq    = 1'b0;
        repeat (3) @(posedge core_clk);
        #2;
        srst = 1'b0;
        t_reset();
        t_pwrdn();
        t_rts();
        t_rs232();
        t_rs485();
        t_rs422();
        report_and_stop();
    end
endmodule // stc_serial_ctrl_tb_top

// ===== src/stc_pkg.sv
// Shared constants and types of the serial transceiver control block
package stc_pkg;

    // ==========================================================
    // Clock and baud limits
    // ==========================================================
    localparam int unsigned CLK_HZ   = 32'h0098_9680;
    localparam int unsigned MAX_BAUD = 32'h0001_C200;
    localparam int unsigned DIV_W    = 32'h0000_0010;
    localparam logic [15:0] MIN_DIV  =
        16'((CLK_HZ + MAX_BAUD - 32'h0000_0001) / MAX_BAUD);
    localparam logic [15:0] DEF_DIV  = 16'h0057;

    // ==========================================================
    // Channel map
    // ==========================================================
    localparam int unsigned NCH     = 32'h0000_0003;
    localparam int unsigned N232    = 32'h0000_0002;
    localparam int unsigned DIFF_CH = 32'h0000_0002;

    // ==========================================================
    // Line levels and reset values
    // ==========================================================
    localparam logic       LINE_IDLE   = 1'h1;
    localparam logic       RTS_RST     = 1'h1;
    localparam logic       PWRDN_RST   = 1'h0;
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam logic [2:0] FIRST_BIT   = 3'h0;

    typedef enum logic [1:0] {
        STC_IDLE  = 2'h0,
        STC_START = 2'h1,
        STC_DATA  = 2'h3,
        STC_STOP  = 2'h2
    } stc_line_state_t;

endpackage

// ===== src/stc_serial_ctrl.sv
// Serial port glue: three UART channels, RS422/RS485 steering, buffers
`timescale 1ns/1ns
module stc_serial_ctrl
    import stc_pkg::*;
#(
    parameter int unsigned CH = NCH
)
(
    input  wire logic                      core_clk_i,
    input  wire logic                      srst_i,
    input  wire logic [CH-1:0][DIV_W-1:0]  ch_div_i,
    input  wire logic [CH-1:0][7:0]        ch_tx_data_i,
    input  wire logic [CH-1:0]             ch_tx_valid_i,
    output logic      [CH-1:0]             ch_tx_ready_o,
    output logic      [CH-1:0][7:0]        ch_rx_data_o,
    output logic      [CH-1:0]             ch_rx_valid_o,
    output logic      [CH-1:0]             ch_rx_ferr_o,
    output logic      [N232-1:0]           rs232_txd_o,
    input  wire logic [N232-1:0]           rs232_rxd_i,
    input  wire logic                      rs485_mode_i,
    input  wire logic                      rts_req_i,
    output logic                           diff_rts_o,
    output logic                           diff_de_o,
    output logic                           diff_txd_o,
    input  wire logic                      diff_rx422_i,
    input  wire logic                      diff_bus_i,
    input  wire logic                      pwrdn_req_i,
    output logic                           rs232_buffer_powerdown_o
);

    // ==========================================================
    // Baud divisor floor
    // ==========================================================
    function automatic logic [DIV_W-1:0] stc_clamp_div(
        input logic [DIV_W-1:0] d
    );
        stc_clamp_div = (d < MIN_DIV) ? MIN_DIV : d;
    endfunction

    logic [CH-1:0][DIV_W-1:0] eff_div;
    logic [CH-1:0]            line_tx;
    logic [CH-1:0]            line_rx;
    logic                     echo_on;

    // ==========================================================
    // RTS and differential driver enable
    // ==========================================================
    // Both flops load from the same request so the enable
    // never lags the RTS level by a cycle
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            diff_rts_o <= RTS_RST;
            diff_de_o  <= ~RTS_RST;
        end
        else
        begin
            diff_rts_o <= rts_req_i;
            diff_de_o  <= ~rts_req_i;
        end
    end

    // ==========================================================
    // RS232 buffer power control
    // ==========================================================
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            rs232_buffer_powerdown_o <= PWRDN_RST;
        else
            rs232_buffer_powerdown_o <= pwrdn_req_i;
    end

    // ==========================================================
    // Receive path steering
    // ==========================================================
    // Shared pair: while we drive, our own bits come back
    assign echo_on = rs485_mode_i && diff_de_o;

    always_comb
    begin
        line_rx = '0;
        for (int i = 0; i < N232; i++)
            line_rx[i] = rs232_rxd_i[i];
        if (!rs485_mode_i)
            line_rx[DIFF_CH] = diff_rx422_i;
        else if (echo_on)
            line_rx[DIFF_CH] = line_tx[DIFF_CH];
        else
            line_rx[DIFF_CH] = diff_bus_i;
    end

    assign rs232_txd_o = line_tx[N232-1:0];
    assign diff_txd_o  = line_tx[DIFF_CH];

    // ==========================================================
    // UART channels
    // ==========================================================
    for (genvar g = 0; g < CH; g++)
    begin : g_chan
        assign eff_div[g] = stc_clamp_div(ch_div_i[g]);

        stc_uart_chan #(
            .W          (DIV_W)
        ) stc_uart_chan_i (
            .core_clk_i (core_clk_i),
            .srst_i     (srst_i),
            .div_i      (eff_div[g]),
            .tx_data_i  (ch_tx_data_i[g]),
            .tx_valid_i (ch_tx_valid_i[g]),
            .tx_ready_o (ch_tx_ready_o[g]),
            .tx_o       (line_tx[g]),
            .rx_i       (line_rx[g]),
            .rx_data_o  (ch_rx_data_o[g]),
            .rx_valid_o (ch_rx_valid_o[g]),
            .rx_ferr_o  (ch_rx_ferr_o[g])
        );
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    rs485_off_a: assert property (
        rs485_mode_i && diff_rts_o |-> !diff_de_o)
        else $error("driver on while RTS high");

    rts_low_on_a: assert property (
        !diff_rts_o |-> diff_de_o)
        else $error("driver off while RTS low");

    de_tracks_rts_a: assert property (
        rts_req_i != diff_rts_o |=> $changed(diff_de_o)
        && diff_de_o == !$past(rts_req_i))
        else $error("driver enable lagged RTS");

    echo_path_a: assert property (
        rs485_mode_i && diff_de_o |-> line_rx[DIFF_CH] == diff_txd_o)
        else $error("transmit not echoed to receiver");

    duplex_path_a: assert property (
        !rs485_mode_i |-> line_rx[DIFF_CH] == diff_rx422_i)
        else $error("RS422 receive pair not selected");

    pwrdn_follow_a: assert property (
        pwrdn_req_i |=> rs232_buffer_powerdown_o ##1
        rs232_buffer_powerdown_o == $past(pwrdn_req_i))
        else $error("powerdown output not following request");

    pwrdn_reset_a: assert property (
        $past(srst_i) |-> !rs232_buffer_powerdown_o)
        else $error("powerdown not low after reset");

    div_floor_a: assert property (
        eff_div[0] >= MIN_DIV && eff_div[1] >= MIN_DIV
        && eff_div[DIFF_CH] >= MIN_DIV)
        else $error("baud divisor below floor");

    tx_accept_a: assert property (
        ch_tx_valid_i[0] && ch_tx_ready_o[0] |=>
        !ch_tx_ready_o[0] && !rs232_txd_o[0])
        else $error("start bit missing after accept");

    chan1_start_a: assert property (
        ch_tx_valid_i[1] && ch_tx_ready_o[1] |=>
        !ch_tx_ready_o[1] && !rs232_txd_o[1])
        else $error("start bit missing on second RS232 channel");

    diff_start_a: assert property (
        ch_tx_valid_i[DIFF_CH] && ch_tx_ready_o[DIFF_CH] |=>
        !ch_tx_ready_o[DIFF_CH] && !diff_txd_o)
        else $error("start bit missing on differential channel");

    rx_pulse_a: assert property (
        ch_rx_valid_o[DIFF_CH] |=> !ch_rx_valid_o[DIFF_CH])
        else $error("receive valid longer than one cycle");

    rs232_rx_a: assert property (
        line_rx[N232-1:0] == rs232_rxd_i)
        else $error("RS232 receiver not on its input pin");

    rts_follow_a: assert property (
        !$past(srst_i) |-> diff_rts_o == $past(rts_req_i))
        else $error("RTS output not one cycle behind request");

    bus_rx_a: assert property (
        rs485_mode_i && !diff_de_o |-> line_rx[DIFF_CH] == diff_bus_i)
        else $error("RS485 receiver not on shared pair");

    // ==========================================================
    // Cover properties
    // ==========================================================
    echo_seen_c: cover property (
        echo_on ##1 ch_rx_valid_o[DIFF_CH]);

    rts_release_c: cover property (
        !diff_rts_o ##1 diff_rts_o && !diff_de_o);

    pwrdn_c: cover property (
        rs232_buffer_powerdown_o ##1 !rs232_buffer_powerdown_o);

    rs422_rx_c: cover property (
        !rs485_mode_i && ch_rx_valid_o[DIFF_CH]);

    bus_rx_c: cover property (
        rs485_mode_i && !diff_de_o && ch_rx_valid_o[DIFF_CH]);

endmodule // stc_serial_ctrl

// ===== src/stc_uart_chan.sv
// One 8N1 serial channel with a transmitter and a receiver
`timescale 1ns/1ns
module stc_uart_chan
    import stc_pkg::*;
#(
    parameter int unsigned W = DIV_W
)
(
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] div_i,
    input  wire logic [7:0]   tx_data_i,
    input  wire logic         tx_valid_i,
    output logic              tx_ready_o,
    output logic              tx_o,
    input  wire logic         rx_i,
    output logic [7:0]        rx_data_o,
    output logic              rx_valid_o,
    output logic              rx_ferr_o
);

    stc_line_state_t tx_st_reg;
    stc_line_state_t rx_st_reg;
    logic [W-1:0]    tx_cnt_reg;
    logic [W-1:0]    rx_cnt_reg;
    logic [2:0]      tx_bit_reg;
    logic [2:0]      rx_bit_reg;
    logic [7:0]      tx_sh_reg;
    logic [7:0]      rx_sh_reg;

    // ==========================================================
    // Transmitter
    // ==========================================================
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            tx_st_reg  <= STC_IDLE;
            tx_o       <= LINE_IDLE;
            tx_ready_o <= 1'h1;
            tx_cnt_reg <= '0;
            tx_bit_reg <= FIRST_BIT;
            tx_sh_reg  <= '0;
        end
        else if (tx_st_reg == STC_IDLE)
        begin
            if (tx_valid_i && tx_ready_o)
            begin
                tx_sh_reg  <= tx_data_i;
                tx_ready_o <= 1'h0;
                tx_o       <= ~LINE_IDLE;
                tx_cnt_reg <= div_i - 1'h1;
                tx_st_reg  <= STC_START;
            end
        end
        else if (tx_cnt_reg != '0)
            tx_cnt_reg <= tx_cnt_reg - 1'h1;
        else
        begin
            tx_cnt_reg <= div_i - 1'h1;
            case (tx_st_reg)
                STC_START:
                begin
                    tx_o       <= tx_sh_reg[0];
                    tx_sh_reg  <= tx_sh_reg >> 1;
                    tx_bit_reg <= FIRST_BIT;
                    tx_st_reg  <= STC_DATA;
                end
                STC_DATA:
                begin
                    if (tx_bit_reg == LAST_BIT)
                    begin
                        tx_o      <= LINE_IDLE;
                        tx_st_reg <= STC_STOP;
                    end
                    else
                    begin
                        tx_o       <= tx_sh_reg[0];
                        tx_sh_reg  <= tx_sh_reg >> 1;
                        tx_bit_reg <= tx_bit_reg + 1'h1;
                    end
                end
                default:
                begin
                    tx_ready_o <= 1'h1;
                    tx_st_reg  <= STC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Receiver, samples mid bit
    // ==========================================================
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            rx_st_reg  <= STC_IDLE;
            rx_cnt_reg <= '0;
            rx_bit_reg <= FIRST_BIT;
            rx_sh_reg  <= '0;
            rx_data_o  <= '0;
            rx_valid_o <= 1'h0;
            rx_ferr_o  <= 1'h0;
        end
        else
        begin
            rx_valid_o <= 1'h0;
            if (rx_st_reg == STC_IDLE)
            begin
                if (rx_i != LINE_IDLE)
                begin
                    rx_cnt_reg <= div_i >> 1;
                    rx_st_reg  <= STC_START;
                end
            end
            else if (rx_cnt_reg != '0)
                rx_cnt_reg <= rx_cnt_reg - 1'h1;
            else
            begin
                rx_cnt_reg <= div_i - 1'h1;
                case (rx_st_reg)
                    STC_START:
                    begin
                        rx_bit_reg <= FIRST_BIT;
                        rx_st_reg  <= (rx_i == LINE_IDLE) ? STC_IDLE
                                                          : STC_DATA;
                    end
                    STC_DATA:
                    begin
                        rx_sh_reg <= {rx_i, rx_sh_reg[7:1]};
                        if (rx_bit_reg == LAST_BIT)
                            rx_st_reg <= STC_STOP;
                        else
                            rx_bit_reg <= rx_bit_reg + 1'h1;
                    end
                    default:
                    begin
                        rx_data_o  <= rx_sh_reg;
                        rx_valid_o <= 1'h1;
                        rx_ferr_o  <= (rx_i != LINE_IDLE);
                        rx_st_reg  <= STC_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // stc_uart_chan
